// File: hdl/strobe_pkg.sv
package strobe_pkg;

	// Memory cycle sequencing
	localparam int STEPS = 16;
	localparam int STEP_W = 4;
	localparam int ROW_STEPS = 5;
	localparam int WR_FIRST = 6;
	localparam int WR_LAST = 13;
	localparam int OE_FIRST = 6;
	localparam int OE_LAST = 15;

	// Local memory widths and the address bit shown late on the ROM select
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int ROM_LATE_BIT = 13;

	// Boot-code windows of the local memory map
	localparam logic [20:0] BOOT_LO_START = 21'h000010;
	localparam logic [20:0] BOOT_LO_END = 21'h00ffff;
	localparam logic [20:0] BOOT_HI_START = 21'h1f0000;
	localparam logic [20:0] BOOT_HI_END = 21'h1fffff;

	// Output reset values
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic MEMBUS_RESET_INIT = 1'b0;

	typedef enum logic [1:0] {
		CYC_READ,
		CYC_WRITE,
		CYC_REFRESH,
		CYC_ID_READ
	} cycle_kind_t;

	typedef struct packed {
		cycle_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mem_req_t;

	function automatic logic in_boot_range(input logic [ADDR_W-1:0] a);
		return (a >= BOOT_LO_START && a <= BOOT_LO_END) ||
			(a >= BOOT_HI_START && a <= BOOT_HI_END);
	endfunction : in_boot_range

	// Read of boot code from ROM: boot-source bit at 0 selects ROM
	function automatic logic rom_hit(input mem_req_t r, input logic boot_ram);
		return (r.kind == CYC_READ || r.kind == CYC_ID_READ) && !boot_ram &&
			in_boot_range(r.addr);
	endfunction : rom_hit

endpackage : strobe_pkg

// File: hdl/phase_sequencer.sv
`timescale 1ns/1ps
module phase_sequencer #(
	parameter int STEPS = strobe_pkg::STEPS
) (
	input wire logic ref_clk_in, // 40 MHz clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic start_in, // Begin a memory cycle
	output logic [strobe_pkg::STEP_W-1:0] step_out, // Current step
	output logic active_out // Cycle in progress
);
	import strobe_pkg::*;

	if (STEPS != (1 << STEP_W) || STEPS <= ROW_STEPS) begin : g_chk
		$error("phase_sequencer: STEPS must equal 2**STEP_W");
	end

	logic [STEP_W-1:0] step_reg, step_next;
	logic active_reg, active_next;

	always_comb begin
		step_next = step_reg;
		active_next = active_reg;
		if (start_in && !active_reg) begin
			step_next = '0;
			active_next = 1'b1;
		end else if (active_reg) begin
			step_next = STEP_W'(step_reg + 1'b1);
			if (step_reg == STEP_W'(STEPS - 1)) begin
				active_next = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			step_reg <= '0;
			active_reg <= 1'b0;
		end else if (ce_in) begin
			step_reg <= step_next;
			active_reg <= active_next;
		end
	end

	assign step_out = step_reg;
	assign active_out = active_reg;

endmodule : phase_sequencer

// File: hdl/local_memory_strobe_control.sv
`timescale 1ns/1ps
module local_memory_strobe_control (
	input wire logic ref_clk_in, // 40 MHz clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable, freezes all state
	input wire logic req_valid_in, // Memory cycle request
	output logic req_ready_out, // Sequencer idle, request taken
	input wire strobe_pkg::mem_req_t req_in, // Kind, address, write data
	input wire logic boot_ram_bit_in, // Boot-source bit, 0 = ROM
	input wire logic adapter_reset_bit_in, // Adapter-reset control bit
	input wire logic system_reset_in, // System reset pin, active high
	output logic row_strobe_n, // Row strobe
	output logic mem_output_enable_n, // Memory output enable
	output logic mem_write_strobe_n, // Memory write strobe
	output logic refresh_indicator, // DRAM refresh in progress
	output logic rom_select_n, // ROM chip select / late A13
	output logic membus_reset_n, // Memory-bus reset for glue logic
	output logic row_phase_out, // Row address on the lines
	output logic [7:0] low_addr_data_bus, // Low address/data lines
	output logic [7:0] high_addr_data_bus // High address/data lines
);
	import strobe_pkg::*;

	logic [STEP_W-1:0] step;
	logic active;
	logic take;
	mem_req_t cycle_reg, cycle_next;
	logic sys_meta_reg, sys_sync_reg;
	logic row_reg, row_next;
	logic oe_n_reg, oe_n_next;
	logic wr_n_reg, wr_n_next;
	logic ref_reg, ref_next;
	logic rom_n_reg, rom_n_next;
	logic bus_rst_n_reg, bus_rst_n_next;
	logic [7:0] low_reg, low_next;
	logic [7:0] high_reg, high_next;

	assign take = req_valid_in && !active;
	assign req_ready_out = !active;

	phase_sequencer #(
		.STEPS(STEPS)
	) u_seq (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.start_in(take),
		.step_out(step),
		.active_out(active)
	);

	// Request held for the whole cycle
	always_comb begin
		cycle_next = take ? req_in : cycle_reg;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cycle_reg <= '0;
		end else if (ce_in) begin
			cycle_reg <= cycle_next;
		end
	end

	// System reset is a pin: two flops before use
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sys_meta_reg <= 1'b1;
			sys_sync_reg <= 1'b1;
		end else if (ce_in) begin
			sys_meta_reg <= system_reset_in;
			sys_sync_reg <= sys_meta_reg;
		end
	end

	// Strobes lag the step count by one edge, so every pin is a flop
	always_comb begin
		logic early;
		logic hit;
		early = 1'b0;
		hit = 1'b0;
		row_next = 1'b0;
		oe_n_next = STROBE_IDLE;
		wr_n_next = STROBE_IDLE;
		ref_next = 1'b0;
		rom_n_next = STROBE_IDLE;
		low_next = low_reg;
		high_next = high_reg;
		bus_rst_n_next = !(adapter_reset_bit_in || sys_sync_reg);
		if (active) begin
			early = step < STEP_W'(ROW_STEPS);
			hit = rom_hit(cycle_reg, boot_ram_bit_in);
			row_next = early;
			ref_next = cycle_reg.kind == CYC_REFRESH;
			if (early) begin
				// Row address, or refresh address, on the lines
				low_next = cycle_reg.addr[15:8];
				high_next = {3'h0, cycle_reg.addr[20:16]};
				rom_n_next = !hit;
			end else begin
				rom_n_next = cycle_reg.addr[ROM_LATE_BIT];
				if (cycle_reg.kind == CYC_WRITE) begin
					// Data stays put from step 5 to the end: covers both edges
					low_next = cycle_reg.wdata[7:0];
					high_next = cycle_reg.wdata[15:8];
				end else begin
					low_next = cycle_reg.addr[7:0];
					high_next = 8'h00;
				end
			end
			if (cycle_reg.kind == CYC_READ && !hit &&
				step >= STEP_W'(OE_FIRST) && step <= STEP_W'(OE_LAST)) begin
				oe_n_next = 1'b0;
			end
			if (cycle_reg.kind == CYC_WRITE &&
				step >= STEP_W'(WR_FIRST) && step <= STEP_W'(WR_LAST)) begin
				wr_n_next = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			row_reg <= 1'b0;
			oe_n_reg <= STROBE_IDLE;
			wr_n_reg <= STROBE_IDLE;
			ref_reg <= 1'b0;
			rom_n_reg <= STROBE_IDLE;
			bus_rst_n_reg <= MEMBUS_RESET_INIT;
			low_reg <= 8'h00;
			high_reg <= 8'h00;
		end else if (ce_in) begin
			row_reg <= row_next;
			oe_n_reg <= oe_n_next;
			wr_n_reg <= wr_n_next;
			ref_reg <= ref_next;
			rom_n_reg <= rom_n_next;
			bus_rst_n_reg <= bus_rst_n_next;
			low_reg <= low_next;
			high_reg <= high_next;
		end
	end

	// Row strobe low exactly while the row or refresh address is out
	assign row_strobe_n = !row_reg;
	assign row_phase_out = row_reg;
	assign mem_output_enable_n = oe_n_reg;
	assign mem_write_strobe_n = wr_n_reg;
	assign refresh_indicator = ref_reg;
	assign rom_select_n = rom_n_reg;
	assign membus_reset_n = bus_rst_n_reg;
	assign low_addr_data_bus = low_reg;
	assign high_addr_data_bus = high_reg;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	a_dram_read_oe: assert property (
		ce_in && active && cycle_reg.kind == CYC_READ &&
		!rom_hit(cycle_reg, boot_ram_bit_in) && step == STEP_W'(OE_FIRST)
		|=> !mem_output_enable_n
	) else $error("output enable not low in DRAM read");

	a_rom_read_oe: assert property (
		!mem_output_enable_n |-> $past(cycle_reg.kind) == CYC_READ &&
		!rom_hit($past(cycle_reg), $past(boot_ram_bit_in))
	) else $error("output enable low outside a DRAM read");

	a_row_strobe_win: assert property (
		ce_in && active && step == STEP_W'(0)
		|=> !row_strobe_n [*5] ##1 row_strobe_n
	) else $error("row strobe not low for exactly five steps");

	a_row_addr_out: assert property (
		ce_in && active && step < STEP_W'(ROW_STEPS)
		|=> low_addr_data_bus == $past(cycle_reg.addr[15:8])
	) else $error("row address missing in row phase");

	a_refresh_flag: assert property (
		ce_in && active |=> refresh_indicator ==
		($past(cycle_reg.kind) == CYC_REFRESH)
	) else $error("refresh indicator wrong");

	a_refresh_idle: assert property (
		ce_in && !active |=> !refresh_indicator
	) else $error("refresh indicator high while idle");

	a_bus_reset_on: assert property (
		ce_in && (adapter_reset_bit_in || sys_sync_reg) |=> !membus_reset_n
	) else $error("bus reset not asserted");

	a_bus_reset_off: assert property (
		ce_in && !adapter_reset_bit_in && !sys_sync_reg |=> membus_reset_n
	) else $error("bus reset not released");

	a_rom_early_sel: assert property (
		ce_in && active && step < STEP_W'(ROW_STEPS) &&
		rom_hit(cycle_reg, boot_ram_bit_in) |=> !rom_select_n
	) else $error("rom select not low for boot read");

	a_rom_early_off: assert property (
		ce_in && active && step < STEP_W'(ROW_STEPS) &&
		!rom_hit(cycle_reg, boot_ram_bit_in) |=> rom_select_n
	) else $error("rom select low for non-boot access");

	a_rom_late_a13: assert property (
		ce_in && active && step >= STEP_W'(ROW_STEPS)
		|=> rom_select_n == $past(cycle_reg.addr[ROM_LATE_BIT])
	) else $error("rom select not carrying A13 late");

	a_write_kind: assert property (
		$fell(mem_write_strobe_n) |-> cycle_reg.kind == CYC_WRITE
	) else $error("write strobe low outside a write");

	a_write_data_held: assert property (
		!mem_write_strobe_n && $past(!mem_write_strobe_n) && $past(ce_in)
		|-> $stable(low_addr_data_bus) && $stable(high_addr_data_bus)
	) else $error("write data changed under write strobe");

	a_write_setup: assert property (
		$fell(mem_write_strobe_n) |->
		{high_addr_data_bus, low_addr_data_bus} == cycle_reg.wdata
	) else $error("write data not valid at strobe fall");

endmodule : local_memory_strobe_control

// File: testbench/memory_side_model.sv
`timescale 1ns/1ps
module memory_side_model (
	input wire logic ref_clk_in, // System clock
	input wire logic rstn_in, // Reset, active low
	input wire logic row_phase_out, // Row address valid
	input wire logic rom_select_n, // ROM select pin
	input wire logic mem_write_strobe_n, // Write strobe
	input wire logic refresh_indicator, // Refresh cycle flag
	input wire logic [7:0] low_addr_data_bus, // Low lines
	input wire logic [7:0] high_addr_data_bus, // High lines
	output logic column_gate_out, // Column strobe allowed
	output logic rom_cs_latched_out, // Latched ROM chip select
	output logic [15:0] cap_fall_out, // Data seen at strobe fall
	output logic [15:0] cap_rise_out // Data seen at strobe rise
);
	logic ws_reg;
	// No column strobe in refresh for DRAMs lacking early-column refresh
	assign column_gate_out = !refresh_indicator;
	// Edges seen one clock late, so the bus sampled is the one held
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ws_reg <= 1'b1;
			rom_cs_latched_out <= 1'b1;
			cap_fall_out <= 16'h0000;
			cap_rise_out <= 16'h0000;
		end else begin
			ws_reg <= mem_write_strobe_n;
			if (row_phase_out) begin
				rom_cs_latched_out <= rom_select_n;
			end
			if (ws_reg && !mem_write_strobe_n) begin
				cap_fall_out <= {high_addr_data_bus, low_addr_data_bus};
			end
			if (!ws_reg && mem_write_strobe_n) begin
				cap_rise_out <= {high_addr_data_bus, low_addr_data_bus};
			end
		end
	end
endmodule : memory_side_model

// File: testbench/local_memory_strobe_control_test.sv
`timescale 1ns/1ps
module local_memory_strobe_control_test;
	import strobe_pkg::*;
	logic ref_clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1;
	logic req_valid_in = 1'b0, boot_ram_bit_in = 1'b0;
	logic adapter_reset_bit_in = 1'b0, system_reset_in = 1'b0;
	mem_req_t req_in = '0;
	logic req_ready_out, row_strobe_n, mem_output_enable_n, mem_write_strobe_n;
	logic refresh_indicator, rom_select_n, membus_reset_n, row_phase_out;
	logic column_gate, rom_cs_latched;
	logic [7:0] low_addr_data_bus, high_addr_data_bus;
	logic [15:0] cap_fall, cap_rise;
	logic [20:0] corner [7] = '{21'h00000f, 21'h000010, 21'h00ffff,
		21'h010000, 21'h1effff, 21'h1f0000, 21'h1fffff};
	int errors = 0, comparisons = 0;
	always #12.5 ref_clk_in = ~ref_clk_in;
	local_memory_strobe_control dut (.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
		.req_ready_out(req_ready_out), .req_in(req_in),
		.boot_ram_bit_in(boot_ram_bit_in),
		.adapter_reset_bit_in(adapter_reset_bit_in),
		.system_reset_in(system_reset_in), .row_strobe_n(row_strobe_n),
		.mem_output_enable_n(mem_output_enable_n),
		.mem_write_strobe_n(mem_write_strobe_n),
		.refresh_indicator(refresh_indicator), .rom_select_n(rom_select_n),
		.membus_reset_n(membus_reset_n), .row_phase_out(row_phase_out),
		.low_addr_data_bus(low_addr_data_bus),
		.high_addr_data_bus(high_addr_data_bus));
	memory_side_model mem (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.row_phase_out(row_phase_out), .rom_select_n(rom_select_n),
		.mem_write_strobe_n(mem_write_strobe_n),
		.refresh_indicator(refresh_indicator),
		.low_addr_data_bus(low_addr_data_bus),
		.high_addr_data_bus(high_addr_data_bus),
		.column_gate_out(column_gate), .rom_cs_latched_out(rom_cs_latched),
		.cap_fall_out(cap_fall), .cap_rise_out(cap_rise));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	function automatic logic hit(input cycle_kind_t k, input logic [20:0] a,
		input logic b);
		return (k == CYC_READ || k == CYC_ID_READ) && !b &&
			((a >= 21'h000010 && a <= 21'h00ffff) || a >= 21'h1f0000);
	endfunction : hit
	// {ready, row, oe, write, refresh, rom, phase, high bus, low bus}
	function automatic logic [22:0] pins(input cycle_kind_t k,
		input logic [20:0] a, input logic [15:0] w, input logic b, input int s);
		logic row, wr, h;
		row = s < 5;
		wr = k == CYC_WRITE;
		h = hit(k, a, b);
		return {s == 15, !row, !(k == CYC_READ && !h && s >= 6),
			!(wr && s >= 6 && s <= 13), k == CYC_REFRESH, row ? !h : a[13], row,
			row ? {3'b000, a[20:16]} : (wr ? w[15:8] : 8'h00),
			row ? a[15:8] : (wr ? w[7:0] : a[7:0])};
	endfunction : pins
	task automatic run(input cycle_kind_t k, input logic [20:0] a,
		input logic [15:0] w);
		int n;
		n = 0;
		while (req_ready_out !== 1'b1 && n < 40) begin
			@(posedge ref_clk_in);
			#2;
			n++;
		end
		if (req_ready_out !== 1'b1) begin
			errors++;
			end_sim();
		end
		req_in = '{k, a, w};
		req_valid_in = 1'b1;
		@(posedge ref_clk_in);
		#2;
		req_valid_in = 1'b0;
		for (int s = 0; s < STEPS; s++) begin
			@(posedge ref_clk_in);
			#2;
			check("pins", pins(k, a, w, boot_ram_bit_in, s), {req_ready_out,
				row_strobe_n, mem_output_enable_n, mem_write_strobe_n,
				refresh_indicator, rom_select_n, row_phase_out, high_addr_data_bus,
				low_addr_data_bus});
		end
		check("latched rom select", !hit(k, a, boot_ram_bit_in), rom_cs_latched);
		check("column gate", k != CYC_REFRESH, column_gate);
		if (k == CYC_WRITE) begin
			check("data at fall", w, cap_fall);
			check("data at rise", w, cap_rise);
		end
		@(posedge ref_clk_in);
		#2;
		check("idle", 6'b111010, {row_strobe_n, mem_output_enable_n,
			mem_write_strobe_n, refresh_indicator, rom_select_n,
			row_phase_out});
	endtask : run
	task automatic bus_reset(input logic ab, sr, input int edges, logic exp);
		adapter_reset_bit_in = ab;
		system_reset_in = sr;
		repeat (edges) @(posedge ref_clk_in);
		#2;
		check("bus reset", exp, membus_reset_n);
	endtask : bus_reset
	initial begin
		void'($urandom(32'hbe06));
		repeat (4) @(posedge ref_clk_in);
		#2;
		check("reset", 3'b101, {req_ready_out, membus_reset_n, rom_select_n});
		rstn_in = 1'b1;
		bus_reset(1'b0, 1'b0, 3, 1'b1);
		bus_reset(1'b1, 1'b0, 1, 1'b0);
		bus_reset(1'b0, 1'b0, 1, 1'b1);
		bus_reset(1'b0, 1'b1, 3, 1'b0);
		bus_reset(1'b0, 1'b0, 3, 1'b1);
		$display("test bus reset done");
		// Clock enable low: no request taken, bus reset frozen
		ce_in = 1'b0;
		req_in = '{CYC_WRITE, 21'h000100, 16'h1234};
		req_valid_in = 1'b1;
		adapter_reset_bit_in = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		#2;
		check("frozen", 3'b111, {req_ready_out, row_strobe_n, membus_reset_n});
		req_valid_in = 1'b0;
		adapter_reset_bit_in = 1'b0;
		ce_in = 1'b1;
		$display("test clock enable done");
		for (int k = 0; k < 4; k++) begin
			for (int b = 0; b < 2; b++) begin
				foreach (corner[i]) begin
					boot_ram_bit_in = b[0];
					run(cycle_kind_t'(k), corner[i], 16'($urandom));
				end
			end
		end
		$display("test corner cycles done");
		repeat (40) begin
			boot_ram_bit_in = 1'($urandom_range(1));
			run(cycle_kind_t'($urandom_range(3)), 21'($urandom), 16'($urandom));
		end
		$display("test random cycles done");
		end_sim();
	end
endmodule : local_memory_strobe_control_test
